// File: rtl/sdas_top.sv
// sdram access sequencer: command sequencing, bank tracking, refresh, avalon registers
//
// Behaviour
// R01 - burst read for oversize reads, cache line fills, sixteen-byte dma reads
// R02 - burst length is always one; bursts are back-to-back single commands
// R03 - beats: 16-bit bus 1,1,2,8; 32-bit bus 1,1,1,4 by access size
// R04 - activate, plain reads, last read auto-precharges; data caught on clock rise
// R05 - after read with auto-precharge, precharge-wait cycles block that bank only
// R06 - ras-to-cas field inserts that many nop cycles after activate
// R07 - read capture delayed by cas latency of one to four cycles
// R08 - small non-cacheable read is one read command, no extra cycles
// R09 - burst write for oversize writes, write-backs, sixteen-byte dma writes
// R10 - activate, plain writes, last write auto-precharges; data with its command
// R11 - after write with auto-precharge, recovery then precharge-wait block that bank
// R12 - small non-cacheable write is one write command
// R13 - keep-rows-open bit drops auto-precharge; same open row skips activate
// R14 - different row in open bank: precharge, wait, activate, then column command
// R15 - one open row tracked per bank independently
// R16 - same-row read at cas latency one gets one nop before the column command
// R17 - other areas leave rows open; every refresh closes all banks
// R18 - refresh_kind_sel 0 with refresh_on 1 auto-refresh with repeats; both 1 self
// R19 - software must refresh often enough when rows stay open
// R20 - refresh request waits until the running bus cycle completes
// R21 - commands encoded on cs, ras, cas, we per the common sdram truth table
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module sdas_top (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  input  wire logic [1:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire sdas_pkg::sdas_req_t  req_in,
  input  wire logic [31:0]          wr_data,
  output logic                      wr_take,
  output logic      [31:0]          rd_data,
  output logic                      rd_valid,
  output logic                      req_done,
  input  wire logic                 refresh_req,
  input  wire logic                 ext_bus_clock,
  output sdas_pkg::sdas_sdram_t     sd_pins,
  input  wire logic [31:0]          dq_in
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // beats per access for a given size and bus width
  function automatic logic [3:0] beats(input logic [1:0] size, input logic bus32);
    logic [3:0] b;
    b = 4'h1;
    case (size)
      2'h2:    b = bus32 ? 4'h1 : 4'h2;                    // R03
      2'h3:    b = bus32 ? 4'h4 : 4'h8;                    // R03 R01 R09
      default: b = 4'h1;                                   // R08 R12
    endcase
    return b;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  sdas_pkg::sdas_regs_t s_q;
  sdas_pkg::sdas_regs_t s_d;

  logic        tick;
  logic        keep_open;
  logic        self_sel;
  logic        auto_sel;
  logic [3:0]  trp;
  logic [3:0]  trcd;
  logic [2:0]  cl_idx;
  logic [3:0]  trwl;
  logic        bus32;
  logic [2:0]  rpt;
  logic        can_take;
  logic        row_hit;
  logic        last_beat;
  logic [9:0]  col_now;

  // field views of the configuration registers
  assign keep_open = s_q.ctrl[`SDAS_CTRL_KEEP];
  assign self_sel  = s_q.ctrl[`SDAS_CTRL_RFON] & s_q.ctrl[`SDAS_CTRL_KIND];  // R18
  assign auto_sel  = s_q.ctrl[`SDAS_CTRL_RFON] & ~s_q.ctrl[`SDAS_CTRL_KIND]; // R18
  assign trp       = {2'h0, s_q.wctl[`SDAS_WAIT_TRP_HI:`SDAS_WAIT_TRP_LO]};
  assign trcd      = {2'h0, s_q.wctl[`SDAS_WAIT_RCD_HI:`SDAS_WAIT_RCD_LO]};
  assign cl_idx    = {1'b0, s_q.wctl[`SDAS_WAIT_CL_HI:`SDAS_WAIT_CL_LO]};  // latency minus one
  assign trwl      = {2'h0, s_q.wctl[`SDAS_WAIT_TRWL_HI:`SDAS_WAIT_TRWL_LO]};
  assign bus32     = s_q.wctl[`SDAS_WAIT_BUS32];
  assign rpt       = s_q.ctrl[`SDAS_CTRL_RPT_HI:`SDAS_CTRL_RPT_LO];

  // rising edge of the external bus clock, seen after its synchroniser
  assign tick = s_q.ck2 & ~s_q.ck3;

  // a request may start only in idle, with no refresh due and its bank settled
  assign can_take = tick && (s_q.st == sdas_pkg::ST_IDLE) && !self_sel
                    && !(s_q.pend && auto_sel) && (s_q.bwait[req_in.bank] == 4'h0);
  assign row_hit  = keep_open && s_q.open_v[req_in.bank]
                    && (s_q.open_row[req_in.bank] == req_in.row);
  assign last_beat = (s_q.beat + 4'h1) == s_q.nbeat;
  assign col_now   = s_q.req.col + {6'h00, s_q.beat};

  // handshake outputs are combinational; data outputs come from flops
  assign req_ready       = ce & req_valid & can_take;
  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign sd_pins         = s_q.pin;
  assign wr_take         = s_q.wr_take;
  assign rd_data         = s_q.rd_data;
  assign rd_valid        = s_q.rd_valid;
  assign req_done        = s_q.done;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = 1'b0;
    s_d.done     = 1'b0;
    s_d.wr_take  = 1'b0;

    // three flops on the external clock, two on the data pins
    s_d.ck1 = ext_bus_clock;
    s_d.ck2 = s_q.ck1;
    s_d.ck3 = s_q.ck2;
    s_d.dq1 = dq_in;
    s_d.dq2 = s_q.dq1;

    // a new refresh request replaces an unserved one; set beats a clear
    if (refresh_req) begin
      s_d.pend = 1'b1;
    end

    // register slave: one wait state, then the access completes
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    if (avs_read && !s_q.ack) begin
      case (avs_address)
        `SDAS_REG_CTRL: s_d.rdata = {25'h0000000, s_q.ctrl};
        `SDAS_REG_WAIT: s_d.rdata = {23'h000000, s_q.wctl};
        `SDAS_REG_STAT: s_d.rdata = {24'h000000, s_q.open_v, 1'b0,
                                     s_q.st == sdas_pkg::ST_SELF, s_q.pend,
                                     s_q.st != sdas_pkg::ST_IDLE};
        default:        s_d.rdata = 32'h00000000;
      endcase
    end
    if (avs_write && s_q.ack) begin
      if (avs_address == `SDAS_REG_CTRL && avs_byteenable[0]) begin
        s_d.ctrl = avs_writedata[6:0];
      end
      if (avs_address == `SDAS_REG_WAIT) begin
        if (avs_byteenable[0]) begin
          s_d.wctl[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          s_d.wctl[8] = avs_writedata[8];
        end
      end
    end

    // sdram side advances once per external clock cycle
    if (tick) begin
      s_d.pin.cmd   = `SDAS_CMD_NOP;
      s_d.pin.dq_oe = 1'b0;
      // per-bank busy time after auto-precharge counts down on its own
      for (int b = 0; b < 4; b++) begin
        if (s_q.bwait[b] != 4'h0) begin
          s_d.bwait[b] = s_q.bwait[b] - 4'h1;              // R05 R11
        end
      end
      // read capture at the programmed latency after each read command
      s_d.pipe = {s_q.pipe[3:0], s_q.pin.cmd == `SDAS_CMD_RD};
      if (s_q.pipe[cl_idx]) begin
        s_d.rd_data  = s_q.dq2;                             // R04 R07
        s_d.rd_valid = 1'b1;
      end

      case (s_q.st)
        sdas_pkg::ST_IDLE: begin
          if (self_sel || (s_q.pend && auto_sel)) begin
            // refresh only starts between bus cycles
            s_d.pin.cmd        = `SDAS_CMD_PRE;            // R20 R21
            s_d.pin.addr       = 13'h0400;                 // all banks
            s_d.open_v         = 4'h0;                     // R17
            s_d.cnt            = trp;
            s_d.pend           = refresh_req;
            s_d.nref           = (rpt == 3'h0) ? 3'h1 : rpt; // R18
            s_d.st             = sdas_pkg::ST_RWAIT;
          end else if (req_valid && s_q.bwait[req_in.bank] == 4'h0) begin
            s_d.req    = req_in;
            s_d.beat   = 4'h0;
            s_d.nbeat  = beats(req_in.size, bus32);        // R02 R03
            s_d.pin.ba = req_in.bank;
            if (row_hit) begin
              // open row: column command at once, one nop before a read at latency one
              s_d.cnt = (!req_in.write && cl_idx == 3'h0) ? 4'h1 : 4'h0; // R13 R16
              s_d.st  = sdas_pkg::ST_COL;
            end else if (keep_open && s_q.open_v[req_in.bank]) begin
              s_d.pin.cmd    = `SDAS_CMD_PRE;              // R14
              s_d.pin.addr   = 13'h0000;
              s_d.open_v[req_in.bank] = 1'b0;
              s_d.cnt        = trp;
              s_d.st         = sdas_pkg::ST_PWAIT;
            end else begin
              s_d.pin.cmd  = `SDAS_CMD_ACT;                // R04 R10 R21
              s_d.pin.addr = req_in.row;
              s_d.cnt      = trcd;                         // R06
              s_d.st       = sdas_pkg::ST_COL;
            end
          end
        end

        sdas_pkg::ST_PWAIT: begin
          if (s_q.cnt != 4'h0) begin
            s_d.cnt = s_q.cnt - 4'h1;                      // R14
          end else begin
            s_d.pin.cmd  = `SDAS_CMD_ACT;                  // R14
            s_d.pin.addr = s_q.req.row;
            s_d.cnt      = trcd;                           // R06
            s_d.st       = sdas_pkg::ST_COL;
          end
        end

        sdas_pkg::ST_COL: begin
          if (s_q.cnt != 4'h0) begin
            s_d.cnt = s_q.cnt - 4'h1;                      // R06 R16
          end else begin
            // one single-beat column command per cycle, auto-precharge on the last unless rows are kept open
            s_d.pin.cmd  = s_q.req.write ? `SDAS_CMD_WR : `SDAS_CMD_RD; // R02 R21
            s_d.pin.addr = {2'h0, last_beat & ~keep_open, col_now};    // R04 R10 R13
            s_d.pin.dqm  = ~s_q.req.be;
            if (s_q.req.write) begin
              s_d.pin.dq_out = wr_data;                    // R10
              s_d.pin.dq_oe  = 1'b1;
              s_d.wr_take    = 1'b1;
            end
            s_d.beat = s_q.beat + 4'h1;
            if (last_beat) begin
              if (keep_open) begin
                s_d.open_v[s_q.req.bank]   = 1'b1;         // R13 R15
                s_d.open_row[s_q.req.bank] = s_q.req.row;  // R15
              end else if (s_q.req.write) begin
                s_d.bwait[s_q.req.bank] = trwl + trp + 4'h1; // R11
              end else begin
                s_d.bwait[s_q.req.bank] = trp + 4'h1;      // R05
              end
              if (s_q.req.write) begin
                s_d.done = 1'b1;
                s_d.st   = sdas_pkg::ST_IDLE;
              end else begin
                s_d.st   = sdas_pkg::ST_DRAIN;
              end
            end
          end
        end

        sdas_pkg::ST_DRAIN: begin
          // the bus cycle ends once the last read command has shifted out of the five-stage capture pipe
          if (s_d.pipe == 5'h00) begin
            s_d.done = 1'b1;
            s_d.st   = sdas_pkg::ST_IDLE;
          end
        end

        sdas_pkg::ST_RWAIT: begin
          if (s_q.cnt != 4'h0) begin
            s_d.cnt = s_q.cnt - 4'h1;
          end else if (self_sel) begin
            s_d.pin.cmd = `SDAS_CMD_REF;                   // R18 R21
            s_d.pin.cke = 1'b0;
            s_d.st      = sdas_pkg::ST_SELF;
          end else begin
            s_d.pin.cmd = `SDAS_CMD_REF;                   // R18 R21
            s_d.nref    = s_q.nref - 3'h1;
            s_d.cnt     = `SDAS_TRC_CYC;
            s_d.st      = sdas_pkg::ST_REF;
          end
        end

        sdas_pkg::ST_REF: begin
          if (s_q.cnt != 4'h0) begin
            s_d.cnt = s_q.cnt - 4'h1;
          end else if (s_q.nref != 3'h0) begin
            s_d.pin.cmd = `SDAS_CMD_REF;                   // R18
            s_d.nref    = s_q.nref - 3'h1;
            s_d.cnt     = `SDAS_TRC_CYC;
          end else begin
            s_d.st = sdas_pkg::ST_IDLE;
          end
        end

        sdas_pkg::ST_SELF: begin
          // leave self-refresh when software clears the selection
          if (!self_sel) begin
            s_d.pin.cke = 1'b1;                            // R18
            s_d.nref    = 3'h0;
            s_d.cnt     = `SDAS_TRC_CYC;
            s_d.st      = sdas_pkg::ST_REF;
          end
        end

        default: begin
          s_d.st = sdas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers; clock enable low freezes everything
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q            <= '0;
      s_q.st         <= sdas_pkg::ST_IDLE;
      s_q.pin.cke    <= 1'b1;
      s_q.pin.cmd    <= `SDAS_CMD_NOP;
      s_q.pin.dqm    <= 4'hf;
      s_q.ctrl       <= `SDAS_CTRL_RST;
      s_q.wctl       <= `SDAS_WAIT_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule

// File: rtl/sdas_defs.svh
// constants of the sdram access sequencer: offsets, fields, resets, commands, timing
`ifndef SDAS_DEFS_SVH
`define SDAS_DEFS_SVH

// ****************************************************************
// register word indices (byte address is four times the index)
// ****************************************************************
`define SDAS_REG_CTRL      2'h0
`define SDAS_REG_WAIT      2'h1
`define SDAS_REG_STAT      2'h2

// ****************************************************************
// sdram_ctrl_reg fields and reset value
// ****************************************************************
`define SDAS_CTRL_KEEP     0
`define SDAS_CTRL_KIND     1
`define SDAS_CTRL_RFON     2
`define SDAS_CTRL_RPT_LO   4
`define SDAS_CTRL_RPT_HI   6
`define SDAS_CTRL_RST      7'h00

// ****************************************************************
// area3_wait_ctrl fields and reset value
// ****************************************************************
`define SDAS_WAIT_TRP_LO   0
`define SDAS_WAIT_TRP_HI   1
`define SDAS_WAIT_RCD_LO   2
`define SDAS_WAIT_RCD_HI   3
`define SDAS_WAIT_CL_LO    4
`define SDAS_WAIT_CL_HI    5
`define SDAS_WAIT_TRWL_LO  6
`define SDAS_WAIT_TRWL_HI  7
`define SDAS_WAIT_BUS32    8
`define SDAS_WAIT_RST      9'h110

// ****************************************************************
// commands as {cs_n, ras_n, cas_n, we_n}
// ****************************************************************
`define SDAS_CMD_NOP       4'h7
`define SDAS_CMD_ACT       4'h3
`define SDAS_CMD_RD        4'h5
`define SDAS_CMD_WR        4'h4
`define SDAS_CMD_PRE       4'h2
`define SDAS_CMD_REF       4'h1

// ****************************************************************
// timing, in external bus clock cycles
// ****************************************************************
`define SDAS_TRC_CYC       4'h4

`endif

// File: rtl/sdas_pkg.sv
// types shared by the sdram access sequencer
`include "sdas_defs.svh"

package sdas_pkg;

  // ****************************************************************
  // sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_PWAIT = 7'h02,
    ST_COL   = 7'h04,
    ST_DRAIN = 7'h08,
    ST_RWAIT = 7'h10,
    ST_REF   = 7'h20,
    ST_SELF  = 7'h40
  } sdas_state_t;

  // access request from an internal master
  typedef struct packed {
    logic        write;
    logic [1:0]  size;   // 0 byte, 1 halfword, 2 word, 3 sixteen bytes
    logic [3:0]  be;
    logic [1:0]  bank;
    logic [12:0] row;
    logic [9:0]  col;
  } sdas_req_t;

  // pins toward the sdram
  typedef struct packed {
    logic        cke;
    logic [3:0]  cmd;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [3:0]  dqm;
    logic [31:0] dq_out;
    logic        dq_oe;
  } sdas_sdram_t;

  // whole state of the sequencer
  typedef struct packed {
    sdas_state_t      st;
    logic             ck1;
    logic             ck2;
    logic             ck3;
    logic [31:0]      dq1;
    logic [31:0]      dq2;
    logic             pend;
    sdas_req_t        req;
    logic [3:0]       beat;
    logic [3:0]       nbeat;
    logic [3:0]       cnt;
    logic [2:0]       nref;
    logic [4:0]       pipe;
    logic [3:0]       open_v;
    logic [3:0][12:0] open_row;
    logic [3:0][3:0]  bwait;
    sdas_sdram_t      pin;
    logic             wr_take;
    logic [31:0]      rd_data;
    logic             rd_valid;
    logic             done;
    logic             ack;
    logic [31:0]      rdata;
    logic [6:0]       ctrl;
    logic [8:0]       wctl;
  } sdas_regs_t;

endpackage

// File: dv/sdas_asserts.sv
// port assertions for the sdram access sequencer
`timescale 1ns/1ps
`include "sdas_defs.svh"

module sdas_asserts (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire logic [1:0]            avs_address,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic                  avs_waitrequest,
  input wire logic                  req_ready,
  input wire logic                  wr_take,
  input wire logic                  rd_valid,
  input wire logic                  req_done,
  input wire sdas_pkg::sdas_sdram_t sd_pins
);
  logic [18:0] prev_q;
  logic [1:0]  rcd_q;
  logic [3:0]  rdp_q;
  logic        keep_q, shut_q, busy_q, nw, col, wacc;

  // new command: change of command, bank or address
  assign nw   = {sd_pins.cmd, sd_pins.ba, sd_pins.addr} != prev_q;
  assign col  = sd_pins.cmd inside {`SDAS_CMD_RD, `SDAS_CMD_WR};
  assign wacc = avs_write && !avs_waitrequest;

  // shadows of settings; shut_q means no row may be open since the last refresh
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= {`SDAS_CMD_NOP, 15'h0};
      rcd_q  <= 2'h0;
      keep_q <= 1'b0;
      shut_q <= 1'b1;
      busy_q <= 1'b0;
      rdp_q  <= 4'h0;
    end else begin
      prev_q <= {sd_pins.cmd, sd_pins.ba, sd_pins.addr};
      if (wacc && avs_address == `SDAS_REG_WAIT) rcd_q <= avs_writedata[3:2];
      if (wacc && avs_address == `SDAS_REG_CTRL) keep_q <= avs_writedata[0];
      if (nw) shut_q <= (sd_pins.cmd == `SDAS_CMD_REF) || (shut_q && sd_pins.cmd != `SDAS_CMD_ACT);
      busy_q <= req_ready || (busy_q && !req_done);
      rdp_q  <= rdp_q + 4'(nw && sd_pins.cmd == `SDAS_CMD_RD) - 4'(rd_valid);
    end
  end

  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_CMD_LEGAL: assert property (
    sd_pins.cmd inside {`SDAS_CMD_NOP, `SDAS_CMD_ACT, `SDAS_CMD_RD, `SDAS_CMD_WR,
                        `SDAS_CMD_PRE, `SDAS_CMD_REF}) else $error("illegal sdram command");
  AST_CMD_HOLD: assert property (
    $changed(sd_pins.cmd) |=> $stable(sd_pins.cmd) [*7]) else $error("command too short");
  AST_RCD: assert property (
    nw && sd_pins.cmd == `SDAS_CMD_ACT |-> ##8 ((rcd_q == 2'h0) ? col
      : sd_pins.cmd == `SDAS_CMD_NOP)) else $error("wrong gap after activate");
  AST_WR_DATA: assert property (
    wr_take |-> ##[0:1] (sd_pins.dq_oe && sd_pins.cmd == `SDAS_CMD_WR))
    else $error("write data not with its command");
  AST_OE_WR: assert property (
    sd_pins.dq_oe |-> sd_pins.cmd == `SDAS_CMD_WR) else $error("data driven without write");
  AST_KEEP_NO_AP: assert property (
    nw && col && keep_q |-> !sd_pins.addr[10]) else $error("auto-precharge with rows kept");
  AST_REF_CLOSE: assert property (
    nw && col |-> !shut_q) else $error("column command without activate");
  AST_REF_HOLD: assert property (
    nw && sd_pins.cmd == `SDAS_CMD_REF |-> !busy_q) else $error("refresh inside an access");
  AST_RDV_AFTER_RD: assert property (
    rd_valid |-> rdp_q != 4'h0) else $error("read data without read command");
  AST_DONE_BOUND: assert property (
    req_ready |-> ##[1:300] req_done) else $error("access never completes");

  COV_WRA: cover property (nw && sd_pins.cmd == `SDAS_CMD_WR && sd_pins.addr[10]);
  COV_REF: cover property (nw && sd_pins.cmd == `SDAS_CMD_REF);
  COV_PRE: cover property (nw && sd_pins.cmd == `SDAS_CMD_PRE);
endmodule

// File: dv/sdas_sdram_model.sv
// behavioural sdram as seen from the sequencer pins
`timescale 1ns/1ps
`include "sdas_defs.svh"

module sdas_sdram_model (
  input  wire logic                  clk_ext,
  input  wire sdas_pkg::sdas_sdram_t pins,
  input  wire logic [2:0]            cl,
  output logic      [31:0]           dq
);
  logic [31:0] mem [0:4095];
  logic [31:0] dat [0:3];
  logic [3:0]  vld;
  int          n [6];

  initial begin
    vld = 4'h0;
    n   = '{default: 0};
  end
  // a slot shows from the falling edge to the next one, covering the synchronised
  // capture just after the rising edge; outside a slot the bus flips
  always @(negedge clk_ext) dq <= vld[0] ? dat[0] : ~dq;

  // commands sampled on the rising edge, one word each; read data is due cl edges later
  always @(posedge clk_ext) begin
    for (int i = 0; i < 3; i++) begin
      dat[i] <= dat[i + 1];
      vld[i] <= vld[i + 1];
    end
    vld[3] <= 1'b0;
    case (pins.cmd)
      `SDAS_CMD_ACT: n[0]++;
      `SDAS_CMD_RD: begin
        n[1]++;
        dat[cl - 3'h1] <= mem[{pins.ba, pins.addr[9:0]}];
        vld[cl - 3'h1] <= 1'b1;
      end
      `SDAS_CMD_WR: begin
        n[2]++;
        mem[{pins.ba, pins.addr[9:0]}] <= pins.dq_oe ? pins.dq_out : ~pins.dq_out;
      end
      `SDAS_CMD_PRE: n[3]++;
      `SDAS_CMD_REF: n[4]++;
      default: ;
    endcase
    if (pins.cmd inside {`SDAS_CMD_RD, `SDAS_CMD_WR} && pins.addr[10]) n[5]++;
  end
endmodule

// File: dv/test_sdas_top.sv
// self-checking bench for the sdram access sequencer
`timescale 1ns/1ps
`include "sdas_defs.svh"

module test_sdas_top;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic                  clk_sys, arst_n, ext_bus_clock, refresh_req, req_valid;
  logic                  avs_read, avs_write, avs_waitrequest, req_ready;
  logic                  wr_take, rd_valid, req_done;
  logic [1:0]            avs_address;
  logic [2:0]            cfg_cl;
  logic [31:0]           avs_writedata, avs_readdata, wr_data, rd_data, dq_in;
  sdas_pkg::sdas_req_t   req_in;
  sdas_pkg::sdas_sdram_t sd_pins;
  int                    err_count, tests_run, s [6];

  sdas_top uut (.ce(1'b1), .avs_byteenable(4'hf), .*);
  sdas_sdram_model u_sd (.clk_ext(ext_bus_clock), .pins(sd_pins), .cl(cfg_cl), .dq(dq_in));

  // bus clock offset so its edges never meet clk_sys
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    ext_bus_clock = 1'b0;
    #7;
    forever #80 ext_bus_clock = ~ext_bus_clock;
  end

  // ****
  // checking and bus tasks
  // ****
  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    err_count++;
    $display("BAD %0t timeout", $time);
    results();
  endtask

  // command counts since the last access began
  task automatic dchk(input int i, input int e);
    chk(32'(u_sd.n[i] - s[i]), 32'(e));
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic avs(input logic w, input logic [1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) tmo();
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    logic [31:0] q;
    avs(1'b1, a, d, q);
  endtask

  // status may lag, so reads repeat until the masked value shows
  task automatic poll(input logic [1:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      avs(1'b0, a, 32'h0, q);
      n++;
    end while ((q & m) !== v && n < 100);
    chk(q & m, v);
    if ((q & m) !== v) tmo();
  endtask

  // one access; write beats advance on wr_take, read beats judged as they come
  task automatic acc(input logic w, input logic [1:0] sz, input logic [1:0] bk,
                     input logic [12:0] row, input logic [9:0] col, input logic [31:0] base,
                     input logic [31:0] m, input int nb, input int rk = -1);
    int n, k;
    logic done;
    s = u_sd.n;
    k = 0;
    done = 1'b0;
    @(posedge clk_sys);
    req_in    <= '{w, sz, 4'hf, bk, row, col};
    req_valid <= 1'b1;
    wr_data   <= base;
    for (n = 0; n < 600 && !done; n++) begin
      @(posedge clk_sys);
      refresh_req <= (rk >= 0 && req_ready === 1'b1);
      if (req_ready === 1'b1) req_valid <= 1'b0;
      if (wr_take === 1'b1) wr_data <= base + 32'(k) + 32'h1;
      if (rd_valid === 1'b1 && m != 32'h0) chk(rd_data & m, (base + 32'(k)) & m);
      if (wr_take === 1'b1 || rd_valid === 1'b1) k++;
      done = (req_done === 1'b1);
    end
    if (!done) tmo();
    chk(32'(k), 32'(nb));
    repeat (2) @(posedge ext_bus_clock);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    poll(`SDAS_REG_CTRL, ALL, 32'h0);
    poll(`SDAS_REG_WAIT, ALL, 32'h110);
    wr(2'h3, ALL);
    poll(2'h3, ALL, 32'h0);
  endtask

  task automatic t_burst();
    wr(`SDAS_REG_WAIT, 32'h165);
    cfg_cl = 3'h3;
    acc(1'b1, 2'h3, 2'h0, 13'h5, 10'h10, 32'ha0, 32'h0, 4);
    dchk(0, 1);
    dchk(2, 4);
    dchk(5, 1);
    acc(1'b0, 2'h3, 2'h0, 13'h5, 10'h10, 32'ha0, ALL, 4);
    dchk(1, 4);
    dchk(5, 1);
    acc(1'b1, 2'h2, 2'h1, 13'h6, 10'h40, 32'hb0, 32'h0, 1);
    acc(1'b0, 2'h0, 2'h1, 13'h6, 10'h40, 32'hb0, ALL, 1);
    dchk(1, 1);
  endtask

  task automatic t_bus16();
    wr(`SDAS_REG_WAIT, 32'h0);
    cfg_cl = 3'h1;
    acc(1'b1, 2'h2, 2'h3, 13'h1, 10'h80, 32'h5670, 32'h0, 2);
    acc(1'b0, 2'h2, 2'h3, 13'h1, 10'h80, 32'h5670, 32'hffff, 2);
    acc(1'b1, 2'h3, 2'h3, 13'h1, 10'h90, 32'h7700, 32'h0, 8);
    acc(1'b0, 2'h3, 2'h3, 13'h1, 10'h90, 32'h7700, 32'hffff, 8);
  endtask

  task automatic t_keep();
    wr(`SDAS_REG_WAIT, 32'h100);
    wr(`SDAS_REG_CTRL, 32'h1);
    acc(1'b1, 2'h2, 2'h1, 13'h7, 10'h20, 32'h11, 32'h0, 1);
    acc(1'b0, 2'h2, 2'h1, 13'h7, 10'h20, 32'h11, ALL, 1);
    dchk(0, 0);
    acc(1'b1, 2'h2, 2'h2, 13'h9, 10'h30, 32'h22, 32'h0, 1);
    acc(1'b0, 2'h2, 2'h1, 13'h7, 10'h20, 32'h11, ALL, 1);
    dchk(0, 0);
    poll(`SDAS_REG_STAT, 32'hf1, 32'h60);
    acc(1'b0, 2'h2, 2'h1, 13'h8, 10'h20, 32'h0, 32'h0, 1);
    dchk(3, 1);
    dchk(0, 1);
  endtask

  // refresh pulse lands inside a write and must wait for it
  task automatic t_ref();
    wr(`SDAS_REG_CTRL, 32'h25);
    acc(1'b1, 2'h2, 2'h2, 13'h9, 10'h31, 32'h33, 32'h0, 1, 10);
    poll(`SDAS_REG_STAT, 32'hf3, 32'h0);
    dchk(4, 2);
    acc(1'b0, 2'h2, 2'h2, 13'h9, 10'h31, 32'h33, ALL, 1);
    dchk(0, 1);
  endtask

  task automatic t_self();
    wr(`SDAS_REG_CTRL, 32'h6);
    poll(`SDAS_REG_STAT, 32'h4, 32'h4);
    wr(`SDAS_REG_CTRL, 32'h0);
    poll(`SDAS_REG_STAT, 32'h5, 32'h0);
  endtask

  // reset for two cycles, then the scenarios
  initial begin
    arst_n        = 1'b0;
    refresh_req   = 1'b0;
    req_valid     = 1'b0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 2'h0;
    avs_writedata = 32'h0;
    wr_data       = 32'h0;
    req_in        = '0;
    cfg_cl        = 3'h2;
    err_count     = 0;
    tests_run     = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_burst();
    t_bus16();
    t_keep();
    t_ref();
    t_self();
    results();
  end
endmodule

bind sdas_top sdas_asserts u_chk (.*);
